// File: rtl/sli_defs.vh
// Constants for the status LED and mode indicator block.
// Assumes a 50 MHz core clock; included by the indicator module.
// Notes on behaviour
// - Measure mode with no host attached shows steady green.
// - Reset mode shows steady red, device not ready to measure.
// - Overload flashes red alternating with the backing colour.
// - Flash backing colour is green without host, blue with host.
// - Factory network address flashes green and blue alternately.
// - Measure mode with host connected shows steady blue.
// - Active auto scaling flashes yellow at 1 Hz.
// - Bootloader ready flashes white at 2 Hz; host starts update within ten seconds.
// - Bootloader waiting flashes red at 1 Hz; host starts update within ten seconds.
// - Identify cycles blue, yellow, red, green stepping every 250 ms.
// - Control input low keeps measure mode; high selects reset mode.
// - Reset control forces amplifier output to zero regardless of sensor load.
// - LED and ready settle after 375 ms, or 13 s if auto scale active at start; mode and zero follow the control at once.
`ifndef SLI_DEFS_VH
`define SLI_DEFS_VH

// ==========================================
// Timing
// ==========================================
`define SLI_CLK_HZ 50000000
`define SLI_DIV_1HZ 2
`define SLI_DIV_2HZ 4
`define SLI_HALF_1HZ (`SLI_CLK_HZ / `SLI_DIV_1HZ)
`define SLI_HALF_2HZ (`SLI_CLK_HZ / `SLI_DIV_2HZ)
`define SLI_STARTUP_MS 375
`define SLI_STARTUP_LONG_MS 13000
`define SLI_CLK_PER_MS (`SLI_CLK_HZ / 1000)

// ==========================================
// Colour codes {red, green, blue}
// ==========================================
`define SLI_OFF 3'h0
`define SLI_BLUE 3'h1
`define SLI_GREEN 3'h2
`define SLI_RED 3'h4
`define SLI_YELLOW 3'h6
`define SLI_WHITE 3'h7

// ==========================================
// Identify step codes
// ==========================================
`define SLI_ID_BLUE 2'h0
`define SLI_ID_YELLOW 2'h1
`define SLI_ID_RED 2'h2
`define SLI_ID_GREEN 2'h3

`endif

// File: rtl/sli_status_led.v
// Status LED pattern generator and reset/measure mode selection.
// Assumes condition inputs synchronous to i_core_clk and active high.
`timescale 1ns/1ps
`include "sli_defs.vh"

module sli_status_led #(
	parameter CLK_HZ = `SLI_CLK_HZ,
	parameter HALF_1HZ = CLK_HZ / `SLI_DIV_1HZ,
	parameter HALF_2HZ = CLK_HZ / `SLI_DIV_2HZ,
	parameter STARTUP_CYC = `SLI_STARTUP_MS * `SLI_CLK_PER_MS,
	parameter STARTUP_LONG_CYC = `SLI_STARTUP_LONG_MS * `SLI_CLK_PER_MS
) (
	// Clock and reset
	input wire i_core_clk,
	input wire i_reset,
	// Operating conditions
	input wire i_reset_measure,
	input wire i_overload,
	input wire i_host_present,
	input wire i_factory_ip,
	input wire i_auto_scale_request,
	input wire i_boot_ready,
	input wire i_boot_waiting,
	input wire i_identify,
	// Indicator and mode outputs
	output reg [2:0] o_led_rgb,
	output reg o_reset_mode,
	output reg o_zero_output,
	output reg o_ready
);

	// ==========================================
	// Startup state machine
	// ==========================================
	localparam ST_INIT = 3'h1;
	localparam ST_WAIT = 3'h2;
	localparam ST_RUN = 3'h4;

	// Sequencer, divider and pattern state
	reg [2:0] state;
	reg [31:0] start_cnt;
	reg [31:0] start_len;
	reg [31:0] cnt_1hz;
	reg [31:0] cnt_2hz;
	reg ph_1hz;
	reg ph_2hz;
	reg [1:0] id_step;
	reg [2:0] next_led;
	wire [2:0] backing;
	wire [2:0] id_colour;
	wire tick_1hz;
	wire tick_2hz;

	// ==========================================
	// Helper functions
	// ==========================================
	// Half period counter wrap test
	function at_end;
		input [31:0] cnt;
		input [31:0] lim;
		begin
			at_end = (cnt >= lim - 32'd1);
		end
	endfunction

	// Flash pick: lit colour in phase one, backing in phase zero
	function [2:0] flash_pick;
		input phase;
		input [2:0] lit;
		input [2:0] back;
		begin
			flash_pick = phase ? lit : back;
		end
	endfunction

	// Identify sequence colour for a step index
	function [2:0] id_colour_of;
		input [1:0] step;
		begin
			case (step)
				`SLI_ID_BLUE: id_colour_of = `SLI_BLUE;
				`SLI_ID_YELLOW: id_colour_of = `SLI_YELLOW;
				`SLI_ID_RED: id_colour_of = `SLI_RED;
				default: id_colour_of = `SLI_GREEN;
			endcase
		end
	endfunction

	// ==========================================
	// Startup timer
	// ==========================================
	// Startup length caught after reset release
	// Picked once, so later changes of the scaling input do not stretch it
	always @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			state <= ST_INIT;
			start_cnt <= 32'h0000_0000;
			start_len <= 32'h0000_0000;
		end else begin
			case (state)
				ST_INIT: begin
					start_len <= i_auto_scale_request ? STARTUP_LONG_CYC : STARTUP_CYC;
					start_cnt <= 32'h0000_0000;
					state <= ST_WAIT;
				end
				ST_WAIT: begin
					if (at_end(start_cnt, start_len))
						state <= ST_RUN;
					else
						start_cnt <= start_cnt + 32'd1;
				end
				ST_RUN: state <= ST_RUN;
				default: state <= ST_INIT;
			endcase
		end
	end

	// ==========================================
	// Flash rate dividers
	// ==========================================
	// One-cycle enables at each half period end
	assign tick_1hz = at_end(cnt_1hz, HALF_1HZ);
	assign tick_2hz = at_end(cnt_2hz, HALF_2HZ);

	// Slow half period counter
	always @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset)
			cnt_1hz <= 32'h0000_0000;
		else if (tick_1hz)
			cnt_1hz <= 32'h0000_0000;
		else
			cnt_1hz <= cnt_1hz + 32'h0000_0001;
	end

	// Fast half period counter
	always @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset)
			cnt_2hz <= 32'h0000_0000;
		else if (tick_2hz)
			cnt_2hz <= 32'h0000_0000;
		else
			cnt_2hz <= cnt_2hz + 32'h0000_0001;
	end

	// Flash phases toggle on their enables
	// Free running, so a new flash may start mid period
	always @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			ph_1hz <= 1'h0;
			ph_2hz <= 1'h0;
		end else begin
			if (tick_1hz)
				ph_1hz <= ~ph_1hz;
			if (tick_2hz)
				ph_2hz <= ~ph_2hz;
		end
	end

	// Identify step advances at the fast rate
	// Parking on blue makes every identify request start the same order
	always @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset)
			id_step <= `SLI_ID_BLUE;
		else if (tick_2hz)
			id_step <= i_identify ? id_step + 2'h1 : `SLI_ID_BLUE;
	end

	// Backing colour for flash patterns
	assign backing = i_host_present ? `SLI_BLUE : `SLI_GREEN;

	// Identify colour for the current step
	assign id_colour = id_colour_of(id_step);

	// ==========================================
	// Pattern selection by fixed priority
	// ==========================================
	// Higher entries win; steady measure colours sit at the bottom, steady reset red sits above address and scaling
	// The LED stays dark until the startup timer expires
	always @* begin
		next_led = `SLI_OFF;
		if (state != ST_RUN)
			next_led = `SLI_OFF;
		else if (i_boot_waiting)
			next_led = flash_pick(ph_1hz, `SLI_RED, backing);
		else if (i_boot_ready)
			next_led = flash_pick(ph_2hz, `SLI_WHITE, backing);
		else if (i_identify)
			next_led = id_colour;
		else if (i_overload)
			next_led = flash_pick(ph_2hz, `SLI_RED, backing);
		else if (i_reset_measure)
			next_led = `SLI_RED;
		else if (i_factory_ip)
			next_led = flash_pick(ph_2hz, `SLI_GREEN, `SLI_BLUE);
		else if (i_auto_scale_request)
			next_led = flash_pick(ph_1hz, `SLI_YELLOW, backing);
		else if (i_host_present)
			next_led = `SLI_BLUE;
		else
			next_led = `SLI_GREEN;
	end

	// ==========================================
	// Output registers
	// ==========================================
	// LED drive register
	always @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset)
			o_led_rgb <= `SLI_OFF;
		else
			o_led_rgb <= next_led;
	end

	// Mode, zero and ready registers
	always @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			o_reset_mode <= 1'h0;
			o_zero_output <= 1'h0;
			o_ready <= 1'h0;
		end else begin
			o_reset_mode <= i_reset_measure;
			o_zero_output <= i_reset_measure;
			o_ready <= (state == ST_RUN) && !i_reset_measure;
		end
	end

endmodule // sli_status_led

// File: tb/sli_far.sv
// Far side model: drives the reset/measure control line.
// Assumes the bench gives the wanted mode as a level.
`timescale 1ns/1ps
module sli_far(
	input wire logic i_want_reset,
	output wire logic o_ctl
);
	// Low keeps measure, high selects reset; passes the wanted level straight through
	assign o_ctl = i_want_reset;
endmodule // sli_far

// File: tb/sli_status_led_assertions.sv
// Checker on the indicator ports.
// Assumes binding to sli_status_led.
`timescale 1ns/1ps
module sli_chk(
	input wire logic i_core_clk, i_reset, i_reset_measure, i_overload, i_host_present,
	input wire logic i_factory_ip, i_auto_scale_request, i_boot_ready, i_boot_waiting,
	input wire logic i_identify, o_reset_mode, o_zero_output, o_ready,
	input wire logic [2:0] o_led_rgb
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	// Higher ranked and quiet conditions
	wire hi = i_boot_waiting | i_boot_ready | i_identify | i_overload;
	wire calm = !(hi | i_factory_ip | i_auto_scale_request | i_reset_measure);
	property p_rm; i_reset_measure |=> o_reset_mode && o_zero_output && !o_ready; endproperty
	a_rm: assert property (p_rm) else $error("reset mode");
	property p_ms; !i_reset_measure |=> !o_zero_output; endproperty
	a_ms: assert property (p_ms) else $error("zero hold");
	property p_grn; o_ready && calm && !i_host_present |=> o_led_rgb == 3'h2; endproperty
	a_grn: assert property (p_grn) else $error("green");
	property p_blu; o_ready && calm && i_host_present |=> o_led_rgb == 3'h1; endproperty
	a_blu: assert property (p_blu) else $error("blue");
	property p_red; o_ready && i_reset_measure && !hi |=> o_led_rgb == 3'h4; endproperty
	a_red: assert property (p_red) else $error("red");
	property p_bw; o_ready && i_boot_waiting && !i_host_present |=> o_led_rgb inside {3'h4, 3'h2};
	endproperty
	a_bw: assert property (p_bw) else $error("boot wait");
	property p_idn; o_ready && i_identify && !i_boot_ready && !i_boot_waiting
		|=> o_led_rgb inside {3'h1, 3'h6, 3'h4, 3'h2}; endproperty
	a_idn: assert property (p_idn) else $error("identify");
	property p_ip; o_ready && i_factory_ip && !hi && !i_reset_measure
		|=> o_led_rgb inside {3'h2, 3'h1}; endproperty
	a_ip: assert property (p_ip) else $error("address");
	property p_off; !o_ready && !o_reset_mode |-> o_led_rgb == 3'h0; endproperty
	a_off: assert property (p_off) else $error("startup");
endmodule // sli_chk

// File: tb/sli_status_led_bench.sv
// Bench: random and corner stimulus for the status indicator.
// Assumes shortened flash and startup counts.
`timescale 1ns/1ps
module sli_status_led_bench;
	logic clk = 0, rst = 1, rm, mode, zero, rdy;
	logic [7:0] c = 0;
	logic [2:0] led, p;
	logic [5:0] w;
	integer seed = 4, bad_count = 0, checks = 0, i, n;
	sli_status_led #(.HALF_1HZ(8), .HALF_2HZ(4), .STARTUP_CYC(10), .STARTUP_LONG_CYC(40)) u_dut(
		.i_core_clk(clk), .i_reset(rst), .i_reset_measure(rm), .i_overload(c[4]),
		.i_host_present(c[0]), .i_factory_ip(c[2]), .i_auto_scale_request(c[1]),
		.i_boot_ready(c[6]), .i_boot_waiting(c[7]), .i_identify(c[5]),
		.o_led_rgb(led), .o_reset_mode(mode), .o_zero_output(zero), .o_ready(rdy));
	sli_far u_far(.i_want_reset(c[3]), .o_ctl(rm));
	// Clock and watchdog
	initial forever #10 clk = ~clk;
	initial begin #100000; bad_count++; report_and_stop; end
	task automatic chk(input string nm, input [2:0] a, b, s);
		checks++;
		if (s !== a && s !== b) begin bad_count++; $display("BAD %s exp %h/%h saw %h", nm, a, b, s); end
	endtask
	task automatic report_and_stop;
		$display("checks %0d bad %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Allowed colour pair for bits {wait,boot,id,ovl,rst,ip,auto,host}
	function automatic [5:0] want(input [7:0] v);
		logic [2:0] k;
		k = v[0] ? 3'h1 : 3'h2;
		casez (v)
			8'b1???????: want = {3'h4, k};
			8'b01??????: want = {3'h7, k};
			8'b0001????: want = {3'h4, k};
			8'b00001???: want = 6'h24;
			8'b000001??: want = 6'h11;
			8'b0000001?: want = {3'h6, k};
			default: want = {k, k};
		endcase
	endfunction
	// Identify order blue, yellow, red, green, then blue again
	function automatic [2:0] step_after(input [2:0] v);
		case (v)
			3'h1: step_after = 3'h6;
			3'h6: step_after = 3'h4;
			3'h4: step_after = 3'h2;
			default: step_after = 3'h1;
		endcase
	endfunction
	// Hold a condition, count colour changes over 16 cycles
	task automatic flash(input [7:0] v, input [2:0] t);
		c = v;
		repeat (3) @(negedge clk);
		p = led;
		n = 0;
		repeat (16) begin @(negedge clk); n += (led !== p); p = led; end
		w = want(v);
		chk("rate", t, t, n[2:0]);
		chk("flash", w[5:3], w[2:0], led);
	endtask
	// Main sequence
	initial begin
		repeat (6) @(negedge clk);
		rst = 0;
		repeat (14) @(negedge clk);
		chk("ready", 1, 1, rdy);
		for (i = 0; i < 300; i++) begin
			c = $random(seed) & $random(seed) & 8'hdf;
			repeat (3) @(negedge clk);
			w = want(c);
			chk("led", w[5:3], w[2:0], led);
			chk("zero", c[3], c[3], zero);
			chk("mode", c[3], c[3], {2'b0, mode & !rdy});
			chk("ready", !c[3], !c[3], rdy);
		end
		flash(8'h10, 4);
		flash(8'h11, 4);
		flash(8'h02, 2);
		flash(8'h40, 4);
		flash(8'h81, 2);
		flash(8'h04, 4);
		c = 8'h20;
		repeat (3) @(negedge clk);
		p = led;
		repeat (4) begin
			repeat (4) @(negedge clk);
			chk("step", step_after(p), step_after(p), led);
			p = led;
		end
		c = 8'h02;
		rst = 1;
		repeat (6) @(negedge clk);
		rst = 0;
		repeat (20) @(negedge clk);
		chk("long", 0, 0, led | rdy);
		repeat (30) @(negedge clk);
		chk("late", 1, 1, rdy);
		report_and_stop;
	end
endmodule // sli_status_led_bench
bind sli_status_led sli_chk u_chk(
	.i_core_clk(i_core_clk),
	.i_reset(i_reset),
	.i_reset_measure(i_reset_measure),
	.i_overload(i_overload),
	.i_host_present(i_host_present),
	.i_factory_ip(i_factory_ip),
	.i_auto_scale_request(i_auto_scale_request),
	.i_boot_ready(i_boot_ready),
	.i_boot_waiting(i_boot_waiting),
	.i_identify(i_identify),
	.o_reset_mode(o_reset_mode),
	.o_zero_output(o_zero_output),
	.o_ready(o_ready),
	.o_led_rgb(o_led_rgb)
);
